/* logic/accel_axis_filter.sv */
`timescale 1ns/1ps
// one axis: first-order high-pass followed by the activity low-pass
module accel_axis_filter import accel_pkg::*; (
	input wire logic mclk, // clock
	input wire logic rst, // async reset, high
	input wire logic clear, // flush state while idle
	input wire logic tick, // new sample strobe
	input wire sample_t raw, // converter sample
	input wire logic hpEn, // high-pass on
	input wire logic lpEn, // activity low-pass on
	input wire logic [1:0] hpCode, // corner code
	input wire logic [2:0] rate, // effective rate code
	output sample_t dataOut, // output data path
	output sample_t actOut // detection path
);
	localparam int W = 22;
	logic signed [W-1:0] xPrev_q, hp_q, lp_q;
	logic signed [W-1:0] xNew, hpSum, hpNext, lpSrc, lpNext;
	logic [4:0] hpShift, lpShift;

	// ----------------------------------------
	// recursion
	// ----------------------------------------
	always_comb begin
		xNew = {{2{raw[11]}}, raw, 8'h00};
		hpSum = hp_q + xNew - xPrev_q;
		// corner tracks the rate since the shift is per sample
		hpShift = 5'(HP_SHIFT_BASE) + 5'(hpCode);
		hpNext = hpSum - (hpSum >>> hpShift);
		lpSrc = hpEn ? hpNext : xNew;
		// faster rate needs a longer average to stay near 8 Hz
		lpShift = 5'(LP_SHIFT_BASE) + 5'(rate);
		lpNext = lp_q + ((lpSrc - lp_q) >>> lpShift);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			xPrev_q <= '0;
			hp_q <= '0;
			lp_q <= '0;
		end else if (clear) begin
			xPrev_q <= '0;
			hp_q <= '0;
			lp_q <= '0;
		end else if (tick) begin
			xPrev_q <= xNew;
			hp_q <= hpNext;
			lp_q <= lpEn ? lpNext : lpSrc;
		end
	end

	// no saturation: large steps through the high-pass wrap
	assign dataOut = hpEn ? hp_q[19:8] : xPrev_q[19:8];
	assign actOut = lpEn ? lp_q[19:8] : dataOut;
endmodule : accel_axis_filter

/* logic/accel_filter_activity_detect.sv */
`timescale 1ns/1ps
// accelerometer filters, settling and activity detection behind an AXI4-Lite port
module accel_filter_activity_detect import accel_pkg::*; #(
	parameter int SAMPLE_DIV = SAMPLE_DIV_DEF, // clocks per sample at 320 Hz
	parameter int SETTLE_LONG = SETTLE_LONG_DEF, // clocks of long settling
	parameter int SETTLE_SHORT = SETTLE_SHORT_DEF, // clocks of short settling
	parameter int TIMER_SLOW = TIMER_SLOW_DEF, // clocks per duration period
	parameter int TIMER_FAST = TIMER_FAST_DEF // clocks per period at top rate
) (
	input wire logic mclk, // clock
	input wire logic rst, // async reset, high
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire sample_t sampleX, // converter x, same clock
	input wire sample_t sampleY, // converter y
	input wire sample_t sampleZ, // converter z
	output logic [2:0] rateSel_q, // rate code to converter
	output logic [2:0] bandwidthSel_q, // clamped antialias code
	output logic awake_q, // moving flag
	output logic activityIrq_q // activity interrupt
);
	localparam int SW = $clog2(SAMPLE_DIV + 1);
	localparam int TW = $clog2(SETTLE_LONG + 1);
	localparam int PW = $clog2(TIMER_SLOW + 1);

	if (SAMPLE_DIV < 64 || SETTLE_SHORT < 16 || SETTLE_LONG < SETTLE_SHORT || TIMER_FAST < 2 ||
		TIMER_SLOW < TIMER_FAST) begin : bad_params
		$error("timing parameters out of range");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? nv[8*i +: 8] : old[8*i +: 8];
		end
	endfunction : merge

	function automatic logic [2:0] clampCode(input logic [2:0] code, input logic [2:0] lim);
		clampCode = (code > lim) ? lim : code;
	endfunction : clampCode

	function automatic logic [12:0] magDiff(input sample_t a, input sample_t b);
		logic signed [12:0] d;
		d = signed'({a[11], a}) - signed'({b[11], b});
		magDiff = d[12] ? 13'(-d) : 13'(d);
	endfunction : magDiff

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [CTRL_W-1:0] ctrl_q;
	logic [ACT_W-1:0] act_q;
	sample_t thr_q [3];
	sample_t ref_q [3];
	sample_t data_q [3];
	sample_t raw [3];
	sample_t dataOut [3];
	sample_t actOut [3];
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic [SW-1:0] sampleCnt_q;
	logic [TW-1:0] settleCnt_q;
	logic [PW-1:0] periodCnt_q;
	logic [7:0] durCnt_q;
	logic tick_q, eval_q, settled_q, pTick_q, overHeld_q, actFlag_q;
	logic activePrev_q, measPrev_q, refPrev_q, refArm_q, capPend_q, refValid_q;
	logic [1:0] mode;
	logic [2:0] rateEff, over;
	logic [7:0] durSet;
	logic active, meas, enterActive, enterMeas, refSel, anyOver, evalGo, durReached;
	logic wakeHit, actHit, capture, doWrite, doRead, evtRead, rdErr;
	logic [31:0] wrVal, rdNext;

	assign mode = ctrl_q[CTRL_MODE +: 2];
	assign meas = mode == MODE_MEAS;
	assign active = meas || mode == MODE_WAKE;
	assign enterActive = active && !activePrev_q;
	assign enterMeas = meas && !measPrev_q;
	assign rateEff = clampCode(ctrl_q[CTRL_ODR +: 3], RATE_MAX);
	assign refSel = act_q[ACTIVITY_REFERENCE_SELECT];
	assign durSet = act_q[ACT_DUR +: 8];
	assign raw[0] = sampleX;
	assign raw[1] = sampleY;
	assign raw[2] = sampleZ;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign evtRead = doRead && s_axi_araddr == ADDR_EVT;

	always_comb begin
		wrVal = '0;
		if (awAddr_q == ADDR_CTRL) begin
			wrVal = merge(32'(ctrl_q), wData_q, wStrb_q);
		end else if (awAddr_q == ADDR_ACT) begin
			wrVal = merge(32'(act_q), wData_q, wStrb_q);
		end else if (awAddr_q == ADDR_THRX) begin
			wrVal = merge(32'(thr_q[0]), wData_q, wStrb_q);
		end else if (awAddr_q == ADDR_THRY) begin
			wrVal = merge(32'(thr_q[1]), wData_q, wStrb_q);
		end else if (awAddr_q == ADDR_THRZ) begin
			wrVal = merge(32'(thr_q[2]), wData_q, wStrb_q);
		end
	end

	always_comb begin
		rdNext = '0;
		rdErr = 1'b0;
		if (s_axi_araddr == ADDR_CTRL) begin
			rdNext = 32'(ctrl_q);
		end else if (s_axi_araddr == ADDR_ACT) begin
			rdNext = 32'(act_q);
		end else if (s_axi_araddr == ADDR_THRX) begin
			rdNext = 32'(thr_q[0]);
		end else if (s_axi_araddr == ADDR_THRY) begin
			rdNext = 32'(thr_q[1]);
		end else if (s_axi_araddr == ADDR_THRZ) begin
			rdNext = 32'(thr_q[2]);
		end else if (s_axi_araddr == ADDR_STAT) begin
			rdNext[STAT_AWAKE] = awake_q;
			rdNext[STAT_SETTLED] = settled_q;
			rdNext[STAT_BW +: 3] = bandwidthSel_q;
			rdNext[STAT_REFOK] = refValid_q;
		end else if (s_axi_araddr == ADDR_EVT) begin
			rdNext[EVT_ACT] = actFlag_q;
		end else if (s_axi_araddr == ADDR_DATX) begin
			rdNext = 32'(data_q[0]);
		end else if (s_axi_araddr == ADDR_DATY) begin
			rdNext = 32'(data_q[1]);
		end else if (s_axi_araddr == ADDR_DATZ) begin
			rdNext = 32'(data_q[2]);
		end else begin
			rdErr = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bresp <= (awAddr_q > ADDR_DATZ || awAddr_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OK;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OK;
		end else if (doRead) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdNext;
			s_axi_rresp <= rdErr ? RESP_SLVERR : RESP_OK;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
		end else begin
			if (doWrite && awAddr_q == ADDR_CTRL) begin
				ctrl_q <= wrVal[CTRL_W-1:0];
			end
			if (wakeHit) begin
				ctrl_q[CTRL_MODE +: 2] <= MODE_MEAS;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			act_q <= ACT_RST;
			thr_q <= '{default: '0};
		end else if (doWrite) begin
			if (awAddr_q == ADDR_ACT) begin
				act_q <= wrVal[ACT_W-1:0];
			end else if (awAddr_q == ADDR_THRX) begin
				thr_q[0] <= wrVal[11:0];
			end else if (awAddr_q == ADDR_THRY) begin
				thr_q[1] <= wrVal[11:0];
			end else if (awAddr_q == ADDR_THRZ) begin
				thr_q[2] <= wrVal[11:0];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rateSel_q <= '0;
			bandwidthSel_q <= '0;
		end else begin
			rateSel_q <= rateEff;
			bandwidthSel_q <= clampCode(ctrl_q[CTRL_BW +: 3], rateEff);
		end
	end

	// ----------------------------------------
	// sample pacing and settling
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sampleCnt_q <= '0;
			tick_q <= 1'b0;
			eval_q <= 1'b0;
		end else begin
			eval_q <= tick_q;
			if (!active || sampleCnt_q == '0) begin
				sampleCnt_q <= active ? SW'((SAMPLE_DIV >> rateEff) - 1) : '0;
				tick_q <= active;
			end else begin
				sampleCnt_q <= sampleCnt_q - 1'b1;
				tick_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			settleCnt_q <= '0;
			settled_q <= 1'b0;
			activePrev_q <= 1'b0;
			measPrev_q <= 1'b0;
		end else begin
			activePrev_q <= active;
			measPrev_q <= meas;
			if (!active) begin
				settleCnt_q <= '0;
				settled_q <= 1'b0;
			end else if (enterActive) begin
				settleCnt_q <= ctrl_q[CTRL_SETTLE] ? TW'(SETTLE_SHORT - 1) : TW'(SETTLE_LONG - 1);
				settled_q <= 1'b0;
			end else if (settleCnt_q != '0) begin
				settleCnt_q <= settleCnt_q - 1'b1;
			end else begin
				settled_q <= 1'b1;
			end
		end
	end

	for (genvar a = 0; a < 3; a++) begin : axis
		accel_axis_filter filt (
			.mclk(mclk),
			.rst(rst),
			.clear(!active),
			.tick(tick_q),
			.raw(raw[a]),
			.hpEn(ctrl_q[CTRL_HPEN]),
			.lpEn(ctrl_q[CTRL_LPEN]),
			.hpCode(ctrl_q[CTRL_HPC +: 2]),
			.rate(rateEff),
			.dataOut(dataOut[a]),
			.actOut(actOut[a])
		);
	end

	// ----------------------------------------
	// activity detection
	// ----------------------------------------
	assign evalGo = eval_q && settled_q;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (refSel) begin
				over[i] = refValid_q && magDiff(actOut[i], ref_q[i]) > {1'b0, thr_q[i]};
			end else begin
				over[i] = magDiff(actOut[i], '0) > {1'b0, thr_q[i]};
			end
			over[i] = over[i] && act_q[ACT_EN + i];
		end
	end
	assign anyOver = |over;
	assign durReached = durSet == '0 || durCnt_q >= durSet;
	assign wakeHit = evalGo && mode == MODE_WAKE && anyOver;
	assign actHit = evalGo && anyOver && (mode == MODE_WAKE || durReached);
	assign capture = capPend_q && evalGo && meas;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			periodCnt_q <= '0;
			pTick_q <= 1'b0;
		end else if (!meas || periodCnt_q == '0) begin
			periodCnt_q <= !meas ? '0 : (rateEff == RATE_MAX) ? PW'(TIMER_FAST - 1) : PW'(TIMER_SLOW - 1);
			pTick_q <= meas;
		end else begin
			periodCnt_q <= periodCnt_q - 1'b1;
			pTick_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			durCnt_q <= '0;
			overHeld_q <= 1'b0;
		end else begin
			if (!meas || (evalGo && !anyOver)) begin
				durCnt_q <= '0;
			end else if (pTick_q && overHeld_q && durCnt_q != 8'hFF) begin
				durCnt_q <= durCnt_q + 1'b1;
			end
			if (!meas) begin
				overHeld_q <= 1'b0;
			end else if (evalGo) begin
				overHeld_q <= anyOver;
			end
		end
	end

	// event flag: a hit in the read cycle survives the clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			actFlag_q <= 1'b0;
			awake_q <= 1'b0;
			activityIrq_q <= 1'b0;
		end else begin
			if (actHit) begin
				actFlag_q <= 1'b1;
			end else if (evtRead) begin
				actFlag_q <= 1'b0;
			end
			if (actHit) begin
				awake_q <= 1'b1;
			end else if (!active) begin
				awake_q <= 1'b0;
			end
			activityIrq_q <= actFlag_q && act_q[ACT_INT] && meas;
		end
	end

	// reference is armed by a fresh referenced selection, taken at the first settled sample after the next measure entry
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			refPrev_q <= 1'b0;
			refArm_q <= 1'b0;
			capPend_q <= 1'b0;
			refValid_q <= 1'b0;
			ref_q <= '{default: '0};
		end else begin
			refPrev_q <= refSel;
			if (!refSel) begin
				refArm_q <= 1'b0;
				capPend_q <= 1'b0;
				refValid_q <= 1'b0;
			end else begin
				if (!refPrev_q) begin
					refArm_q <= 1'b1;
				end else if (enterMeas && refArm_q) begin
					refArm_q <= 1'b0;
					capPend_q <= 1'b1;
				end else if (capture) begin
					capPend_q <= 1'b0;
				end
				if (capture) begin
					refValid_q <= 1'b1;
					ref_q <= actOut;
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_q <= '{default: '0};
		end else if (evalGo) begin
			data_q <= dataOut;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence wakeDetect_s;
		evalGo && mode == MODE_WAKE && anyOver;
	endsequence
	sequence startUp_s;
		enterActive;
	endsequence

	rate_limit_a: assert property (rateSel_q <= RATE_MAX) else $error("rate code too high");
	bw_clamp_a: assert property (bandwidthSel_q <= rateSel_q) else $error("bandwidth over half rate");
	settle_hold_a: assert property (startUp_s |=> !settled_q [*8]) else $error("released before settling");
	wake_single_a: assert property (wakeDetect_s |=> actFlag_q && awake_q) else $error("wake hit missed");
	wake_return_a: assert property (wakeDetect_s |=> mode == MODE_MEAS) else $error("no return to measure");
	wake_noirq_a: assert property ((mode == MODE_WAKE) [*2] |-> !activityIrq_q) else $error("irq in wake-up");
	act_any_a: assert property (evalGo && meas && anyOver && durReached |=> actFlag_q) else $error("activity lost");
	ref_capture_a: assert property (capture |=> refValid_q && ref_q[0] == $past(actOut[0]))
		else $error("reference not captured");
endmodule : accel_filter_activity_detect

/* logic/accel_pkg.sv */
// shared constants for the accelerometer filter and activity block
package accel_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ACT = 8'h04;
	localparam logic [7:0] ADDR_THRX = 8'h08;
	localparam logic [7:0] ADDR_THRY = 8'h0C;
	localparam logic [7:0] ADDR_THRZ = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam logic [7:0] ADDR_EVT = 8'h18;
	localparam logic [7:0] ADDR_DATX = 8'h1C;
	localparam logic [7:0] ADDR_DATY = 8'h20;
	localparam logic [7:0] ADDR_DATZ = 8'h24;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CTRL_MODE = 0;
	localparam int CTRL_ODR = 2;
	localparam int CTRL_BW = 5;
	localparam int CTRL_HPC = 8;
	localparam int CTRL_HPEN = 10;
	localparam int CTRL_LPEN = 11;
	localparam int CTRL_SETTLE = 12;
	localparam int CTRL_W = 13;
	localparam int ACT_EN = 0;
	localparam int ACTIVITY_REFERENCE_SELECT = 3;
	localparam int ACT_INT = 4;
	localparam int ACT_DUR = 8;
	localparam int ACT_W = 16;
	localparam int STAT_AWAKE = 0;
	localparam int STAT_SETTLED = 1;
	localparam int STAT_BW = 2;
	localparam int STAT_REFOK = 5;
	localparam int EVT_ACT = 0;
	localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
	localparam logic [ACT_W-1:0] ACT_RST = 16'h0000;
	localparam logic [1:0] MODE_STBY = 2'h0;
	localparam logic [1:0] MODE_WAKE = 2'h1;
	localparam logic [1:0] MODE_MEAS = 2'h2;
	localparam logic [2:0] RATE_MAX = 3'h4;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 125000000;
	localparam int CLK_MHZ = CLK_HZ / 1000000;
	localparam int BASE_RATE_HZ = 320;
	localparam int SAMPLE_DIV_DEF = CLK_HZ / BASE_RATE_HZ;
	localparam int SETTLE_LONG_US = 462500;
	localparam int SETTLE_SHORT_US = 20000;
	localparam int TIMER_SLOW_US = 8250;
	localparam int TIMER_FAST_US = 2060;
	localparam int SETTLE_LONG_DEF = SETTLE_LONG_US * CLK_MHZ;
	localparam int SETTLE_SHORT_DEF = SETTLE_SHORT_US * CLK_MHZ;
	localparam int TIMER_SLOW_DEF = TIMER_SLOW_US * CLK_MHZ;
	localparam int TIMER_FAST_DEF = TIMER_FAST_US * CLK_MHZ;
	localparam int HP_SHIFT_BASE = 5;
	localparam int LP_SHIFT_BASE = 3;
	typedef logic [11:0] sample_t;
endpackage : accel_pkg

/* tb/accel_filter_activity_detect_test.sv */
`timescale 1ns/1ps
// self-checking bench for the filter and activity block
module accel_filter_activity_detect_test import accel_pkg::*; ;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	sample_t sampleX = '0, sampleY = '0, sampleZ = '0;
	logic [2:0] rateSel_q, bandwidthSel_q;
	logic awake_q, activityIrq_q;
	int failures = 0;
	int tests_run = 0;
	always #4 mclk = ~mclk;
	accel_filter_activity_detect #(.SAMPLE_DIV(256), .SETTLE_LONG(400), .SETTLE_SHORT(40), .TIMER_SLOW(300),
		.TIMER_FAST(75)) uut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sampleX,
		.sampleY, .sampleZ, .rateSel_q, .bandwidthSel_q, .awake_q, .activityIrq_q);
	axi_host_model host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_sim();
		if (failures == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	task automatic hang();
		failures++;
		end_sim();
	endtask : hang
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		host.wr(a, d, r);
		if (r === 2'h3) hang();
		check("write response", r, RESP_OK);
	endtask : wr
	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [1:0] r;
		logic [31:0] d;
		host.rd(a, d, r);
		if (r === 2'h3) hang();
		check(what, d & m, e);
	endtask : rdChk
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask : idle
	// bounded so a design that never flags motion still reaches the verdict
	task automatic waitAwake();
		int n;
		for (n = 0; n < 1000 && awake_q !== 1'b1; n++) @(posedge mclk);
		if (n == 1000) hang();
	endtask : waitAwake
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic resetValues();
		logic [1:0] r;
		logic [31:0] d;
		rdChk("ctrl reset", ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
		rdChk("act reset", ADDR_ACT, 32'hFFFFFFFF, 32'h0);
		check("rate reset", rateSel_q, 3'h0);
		check("bw reset", bandwidthSel_q, 3'h0);
		host.rd(8'h40, d, r);
		if (r === 2'h3) hang();
		check("unmapped resp", r, RESP_SLVERR);
		check("unmapped data", d, 32'h0);
	endtask : resetValues
	task automatic clampSweep();
		for (int r = 0; r < 5; r++) begin
			wr(ADDR_CTRL, (r << CTRL_ODR) | (4 << CTRL_BW));
			rdChk("stat bw", ADDR_STAT, 32'h1C, r << STAT_BW);
			check("rate code", rateSel_q, r);
			check("clamped bw", bandwidthSel_q, r);
		end
		wr(ADDR_CTRL, (4 << CTRL_ODR) | (1 << CTRL_BW));
		rdChk("free bw", ADDR_STAT, 32'h1C, 1 << STAT_BW);
	endtask : clampSweep
	task automatic settleLong();
		wr(ADDR_CTRL, MODE_MEAS);
		idle(300);
		rdChk("still settling", ADDR_STAT, 32'h2, 32'h0);
		idle(200);
		rdChk("settled", ADDR_STAT, 32'h2, 32'h2);
		wr(ADDR_CTRL, 32'h0);
	endtask : settleLong
	task automatic absDetect();
		wr(ADDR_THRX, 32'h32);
		wr(ADDR_ACT, 32'h11);
		sampleX <= 12'h064;
		wr(ADDR_CTRL, (1 << CTRL_SETTLE) | MODE_MEAS);
		// let the first unsettled sample pass before looking
		idle(4);
		rdChk("data withheld", ADDR_DATX, 32'hFFF, 32'h0);
		waitAwake();
		idle(2);
		check("irq", activityIrq_q, 1'b1);
		rdChk("event flag", ADDR_EVT, 32'h1, 32'h1);
		rdChk("data path", ADDR_DATX, 32'hFFF, 32'h064);
		wr(ADDR_CTRL, 32'h0);
		idle(2);
		check("awake cleared", {awake_q, activityIrq_q}, 2'h0);
	endtask : absDetect
	task automatic axisDuration();
		wr(ADDR_THRY, 32'h32);
		wr(ADDR_ACT, 32'h202);
		wr(ADDR_CTRL, (1 << CTRL_SETTLE) | MODE_MEAS);
		idle(1500);
		check("disabled axis", awake_q, 1'b0);
		sampleY <= 12'hF9C;
		idle(290);
		check("duration hold", awake_q, 1'b0);
		waitAwake();
		wr(ADDR_CTRL, 32'h0);
		sampleY <= 12'h000;
		// top rate: two short periods end well before one long period would
		wr(ADDR_CTRL, (4 << CTRL_ODR) | (1 << CTRL_SETTLE) | MODE_MEAS);
		idle(100);
		sampleY <= 12'hF9C;
		idle(250);
		check("fast period", awake_q, 1'b1);
		wr(ADDR_CTRL, 32'h0);
		sampleY <= 12'h000;
	endtask : axisDuration
	task automatic refDetect();
		wr(ADDR_ACT, 32'h09);
		wr(ADDR_CTRL, (1 << CTRL_SETTLE) | MODE_MEAS);
		idle(1500);
		check("near reference", awake_q, 1'b0);
		rdChk("reference held", ADDR_STAT, 32'h20, 32'h20);
		sampleX <= 12'h0C8;
		waitAwake();
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_ACT, 32'h01);
		wr(ADDR_ACT, 32'h09);
		wr(ADDR_CTRL, (1 << CTRL_SETTLE) | MODE_MEAS);
		idle(1500);
		check("renewed reference", awake_q, 1'b0);
		wr(ADDR_CTRL, 32'h0);
	endtask : refDetect
	// constant input: high-pass output decays, faster for the lower code
	task automatic hpDecay();
		wr(ADDR_ACT, 32'h0);
		sampleX <= 12'h064;
		for (int c = 3; c >= 0; c -= 3) begin
			wr(ADDR_CTRL, (1 << CTRL_HPEN) | (c << CTRL_HPC) | MODE_MEAS);
			idle(6000);
			rdChk("hp decay", ADDR_DATX, 32'hFC0, (c == 3) ? 32'h040 : 32'h0);
			wr(ADDR_CTRL, 32'h0);
		end
	endtask : hpDecay
	// averaging delays the activity onset by several samples
	task automatic lpDelay();
		wr(ADDR_ACT, 32'h01);
		wr(ADDR_CTRL, (1 << CTRL_LPEN) | (1 << CTRL_HPEN) | (3 << CTRL_HPC) | MODE_MEAS);
		idle(1000);
		check("averaged onset", awake_q, 1'b0);
		waitAwake();
		wr(ADDR_CTRL, 32'h0);
	endtask : lpDelay
	task automatic wakeDetect();
		wr(ADDR_ACT, 32'h511);
		wr(ADDR_CTRL, (1 << CTRL_SETTLE) | MODE_WAKE);
		waitAwake();
		rdChk("back to measure", ADDR_CTRL, 32'h3, MODE_MEAS);
	endtask : wakeDetect
	initial begin
		idle(3);
		rst <= 1'b0;
		resetValues();
		clampSweep();
		settleLong();
		absDetect();
		axisDuration();
		refDetect();
		hpDecay();
		lpDelay();
		wakeDetect();
		end_sim();
	end
endmodule : accel_filter_activity_detect_test

/* tb/axi_host_model.sv */
`timescale 1ns/1ps
// AXI4-Lite host model that reaches the register port
module axi_host_model (
	input wire logic mclk, // clock
	output logic [7:0] s_axi_awaddr, // aw addr
	output logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	output logic [31:0] s_axi_wdata, // w data
	output logic [3:0] s_axi_wstrb, // w strobes
	output logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	output logic s_axi_bready, // b ready
	output logic [7:0] s_axi_araddr, // ar addr
	output logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic [1:0] s_axi_rresp, // r resp
	input wire logic s_axi_rvalid, // r valid
	output logic s_axi_rready // r ready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	// ----------------------------------------
	// bus cycles; a response of 3 marks a hang
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		r = 2'h3;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 99 && r === 2'h3; n++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) r = s_axi_bresp;
		end
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		r = 2'h3;
		d = '0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 99 && r === 2'h3; n++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) {d, r} = {s_axi_rdata, s_axi_rresp};
		end
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : axi_host_model
